// File: logic/vgc_top.sv
`timescale 1ns/1ps

module vgc_top
   import vgc_pkg::*;
#(
   parameter int GRID_N    = GRID_COUNT,
   parameter int SEG_N     = SEG_COUNT,
   parameter int BLINK_CYC = BLINK_HALF_CYC
)
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              srst,
   // Configuration pins
   input  wire logic              interface_mode_sel,
   input  wire logic              bus_style_sel,
   input  wire logic              display_size_sel0,
   input  wire logic              display_size_sel1,
   // 68-style host bus
   input  wire logic              host_e,
   input  wire logic              host_rs,
   input  wire logic              host_rw,
   input  wire logic [7:0]        db_in,
   output logic      [7:0]        db_out,
   output logic                   db_oe,
   // Display drive
   output logic      [GRID_N-1:0] grid,
   output logic      [SEG_N-1:0]  seg,
   // Status
   output logic                   data_length_bit,
   output logic      [6:0]        address_pointer
);

   // Geometry is fixed by the scan order; counters are 5 and 26 bits
   if (SEG_N != SLOTS * DOTS_PER_ROW || GRID_N < GRID_COUNT ||
       GRID_N > 31 || BLINK_CYC < 1 || BLINK_CYC > (1 << 26))
   begin : g_bad_param
      $error("vgc_top: unsupported parameter value");
   end

   localparam logic [7:0]  STEP_LAST  = 8'(STEP_CYC - 1);
   localparam logic [25:0] BLINK_LAST = 26'(BLINK_CYC - 1);

   // Host side state
   logic       e_prev_r;
   logic       phase_r;
   logic [3:0] hi_nib_r;
   logic       dl_r;
   logic       id_r;
   logic       disp_on_r;
   logic       cursor_en_r;
   logic       blink_en_r;
   logic       ptr_glyph_r;
   logic [6:0] ac_r;
   logic [7:0] db_out_r;
   logic       db_oe_r;
   logic [7:0] char_mem [CHAR_WORDS];

   // Refresh side state
   logic [7:0]       div_r;
   logic [3:0]       slot_r;
   logic [4:0]       grid_idx_r;
   logic [4:0]       digits_r;
   logic             cap_done_r;
   logic [SEG_N-6:0] shift_r;
   logic [SEG_N-1:0] seg_r;
   logic [GRID_N-1:0] grid_r;
   logic [25:0]      blink_cnt_r;
   logic             blink_phase_r;

   // Host strobe decode; data is taken on the falling edge of E
   wire m68       = interface_mode_sel & bus_style_sel;
   wire e_fall    = m68 & e_prev_r & ~host_e;
   wire byte_done = e_fall & (dl_r | phase_r);
   wire cmd_wr    = byte_done & ~host_rs & ~host_rw;
   wire data_wr   = byte_done & host_rs & ~host_rw;
   wire data_acc  = byte_done & host_rs;
   wire rd_cycle  = m68 & host_e & host_rw;

   // Byte assembly: low nibble completes a 4-bit transfer
   wire [7:0] wr_byte = dl_r ? db_in : {hi_nib_r, db_in[7:4]};

   // Command classes, highest set bit wins
   wire is_dd    = wr_byte[7];
   wire is_cg    = wr_byte[7:6] == 2'b01;
   wire is_fn    = wr_byte[7:5] == 3'b001;
   wire is_disp  = wr_byte[7:3] == 5'b00001;
   wire is_entry = wr_byte[7:2] == 6'b000001;
   wire is_home  = wr_byte[7:1] == 7'b0000001;

   // Pointer step; glyph addresses wrap inside 64 bytes
   wire [6:0] ac_step = id_r ? ac_r + 7'h01 : ac_r - 7'h01;
   wire [6:0] ac_next = ptr_glyph_r ? {1'b0, ac_step[5:0]} : ac_step;

   // Read path; busy is never reported so no wait state exists
   wire [7:0] glyph_host_q;
   wire [7:0] data_q  = ptr_glyph_r ? glyph_host_q : char_mem[ac_r];
   wire [7:0] rd_byte = host_rs ? data_q : {BUSY_VALUE, ac_r};
   wire [7:0] rd_hi   = {rd_byte[7:4], NIB_IDLE};
   wire [7:0] rd_lo   = {rd_byte[3:0], NIB_IDLE};
   wire [7:0] rd_lane = dl_r ? rd_byte : (phase_r ? rd_lo : rd_hi);

   // E history and nibble phase
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         e_prev_r <= 1'b0;
         phase_r  <= 1'b0;
         hi_nib_r <= NIB_IDLE;
      end
      else
      begin
         e_prev_r <= host_e;
         if (e_fall && !dl_r)
         begin
            phase_r <= ~phase_r;
            if (!phase_r)
               hi_nib_r <= db_in[7:4];
         end
         else if (dl_r)
            phase_r <= 1'b0;
      end
   end

   // Mode bits set by command bytes
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         dl_r        <= DL_RESET;
         id_r        <= ID_RESET;
         disp_on_r   <= DISP_RESET;
         cursor_en_r <= CURSOR_RESET;
         blink_en_r  <= BLINK_RESET;
      end
      else if (cmd_wr)
      begin
         if (is_fn)
            dl_r <= wr_byte[4];
         if (is_disp)
         begin
            disp_on_r   <= wr_byte[2];
            cursor_en_r <= wr_byte[1];
            blink_en_r  <= wr_byte[0];
         end
         if (is_entry)
            id_r <= wr_byte[1];
      end
   end

   // Address pointer: set by command, stepped on every data access
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         ac_r        <= AC_RESET;
         ptr_glyph_r <= 1'b0;
      end
      else if (cmd_wr && is_dd)
      begin
         ac_r        <= wr_byte[6:0];
         ptr_glyph_r <= 1'b0;
      end
      else if (cmd_wr && is_cg)
      begin
         ac_r        <= {1'b0, wr_byte[5:0]};
         ptr_glyph_r <= 1'b1;
      end
      else if (cmd_wr && is_home)
      begin
         ac_r        <= AC_RESET;
         ptr_glyph_r <= 1'b0;
      end
      else if (data_acc)
         ac_r <= ac_next;
   end

   // Character code store; spare addresses are general storage
   always_ff @(posedge clock)
   begin
      if (data_wr && !ptr_glyph_r)
         char_mem[ac_r] <= wr_byte;
   end

   // Bus drive only while E is high on a read
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         db_oe_r  <= 1'b0;
         db_out_r <= 8'h00;
      end
      else
      begin
         db_oe_r  <= rd_cycle;
         db_out_r <= rd_cycle ? rd_lane : 8'h00;
      end
   end

   // Refresh scan: one slot per step, 2 lines x 8 rows per grid
   wire       step_en   = div_r == STEP_LAST;
   wire [2:0] row       = slot_r[2:0];
   wire       line      = slot_r[3];
   wire       last_slot = slot_r == SLOT_LAST;
   wire       last_grid = grid_idx_r == digits_r - 5'h01;
   wire [6:0] pos       = {line, 1'b0, grid_idx_r};

   // Glyph fetch from the refresh port only
   wire [7:0] scan_code = char_mem[pos];
   wire       user_sel  = scan_code[7:4] == USER_HI;
   wire [5:0] glyph_scan_addr = {scan_code[2:0], row};
   wire [7:0] glyph_scan_q;
   wire [4:0] user_row  = glyph_scan_q[4:0];

   // Stand-in glyph ROM row until the real font table is dropped in
   wire [4:0] rom_row  = scan_code[4:0] ^ {2'b00, row};
   wire [4:0] base_row = user_sel ? user_row : rom_row;

   // Glyph store; the refresh port never waits on the host port
   vgc_glyph_ram u_glyph (
      .clock     (clock),
      .wr_en     (data_wr & ptr_glyph_r),
      .host_addr (ac_r[5:0]),
      .wr_data   (wr_byte),
      .host_q    (glyph_host_q),
      .scan_addr (glyph_scan_addr),
      .scan_q    (glyph_scan_q)
   );

   // Cursor and blink; a glyph-RAM pointer still compares, meaninglessly
   wire hit        = ac_r == pos;
   wire cur_dot    = hit & cursor_en_r & (row == CURSOR_ROW);
   wire blink_show = hit & blink_en_r & blink_phase_r;
   wire [4:0] lit_row = base_row | {DOTS_PER_ROW{cur_dot}};
   wire [4:0] pat = !disp_on_r ? DOTS_OFF :
                    (blink_show ? DOTS_ALL : lit_row);

   // Size pins pick the digit count
   wire [4:0] size_pick = display_size_sel1 ? DIGITS_24 :
                          (display_size_sel0 ? DIGITS_20 : DIGITS_16);

   // Grid enables: unused grids never select
   wire [GRID_N-1:0] grid_ok;
   wire [GRID_N-1:0] grid_hot;
   genvar g;
   for (g = 0; g < GRID_N; g++)
   begin : g_grid
      assign grid_ok[g]  = 5'(g) < digits_r;
      assign grid_hot[g] = grid_ok[g] & (grid_idx_r == 5'(g));
   end

   // Size pins caught once, the cycle after reset lifts
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         cap_done_r <= 1'b0;
         digits_r   <= DIGITS_24;
      end
      else if (!cap_done_r)
      begin
         cap_done_r <= 1'b1;
         digits_r   <= size_pick;
      end
   end

   // Step divider; runs free of host traffic
   always_ff @(posedge clock)
   begin
      if (srst)
         div_r <= 8'h00;
      else
         div_r <= step_en ? 8'h00 : div_r + 8'h01;
   end

   // Slot and grid counters
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         slot_r     <= 4'h0;
         grid_idx_r <= 5'h00;
      end
      else if (step_en)
      begin
         slot_r <= slot_r + 4'h1;
         if (last_slot)
            grid_idx_r <= last_grid ? 5'h00 : grid_idx_r + 5'h01;
      end
   end

   // Shift and latch; old pattern stays up while the next loads
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         shift_r <= '0;
         seg_r   <= '0;
         grid_r  <= '0;
      end
      else if (step_en)
      begin
         shift_r <= {shift_r[SEG_N-11:0], pat};
         if (last_slot)
         begin
            seg_r  <= {shift_r, pat};
            grid_r <= grid_hot;
         end
      end
   end

   // Blink half period
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         blink_cnt_r   <= 26'h0000000;
         blink_phase_r <= 1'b0;
      end
      else if (blink_cnt_r == BLINK_LAST)
      begin
         blink_cnt_r   <= 26'h0000000;
         blink_phase_r <= ~blink_phase_r;
      end
      else
         blink_cnt_r <= blink_cnt_r + 26'h0000001;
   end

   // Outputs straight from flip-flops
   assign db_out          = db_out_r;
   assign db_oe           = db_oe_r;
   assign grid            = grid_r;
   assign seg             = seg_r;
   assign data_length_bit = dl_r;
   assign address_pointer = ac_r;

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   sequence s_hi_nib;
      e_fall && !dl_r && !phase_r;
   endsequence

   sequence s_status_rd;
      rd_cycle && !host_rs && !phase_r;
   endsequence

   property p_busy_zero;
      s_status_rd |=> db_oe_r && !db_out_r[7];
   endproperty
   a_busy_zero: assert property (p_busy_zero)
      else $error("busy bit read as one");

   property p_ptr_step;
      data_acc && id_r && !ptr_glyph_r |=>
         ac_r == 7'($past(ac_r) + 7'h01);
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("pointer did not step after data access");

   property p_nibble;
      s_hi_nib |=> phase_r && $stable(ac_r) && !cmd_wr;
   endproperty
   a_nibble: assert property (p_nibble)
      else $error("high nibble committed a byte");

   property p_user_pick;
      disp_on_r && user_sel && !hit |-> pat == glyph_scan_q[4:0];
   endproperty
   a_user_pick: assert property (p_user_pick)
      else $error("user glyph row not shown");

   property p_cursor_row;
      disp_on_r && cur_dot && !blink_show |-> pat == DOTS_ALL;
   endproperty
   a_cursor_row: assert property (p_cursor_row)
      else $error("cursor row not lit");

   property p_grid_off;
      (grid_r & ~grid_ok) == '0 && $onehot0(grid_r);
   endproperty
   a_grid_off: assert property (p_grid_off)
      else $error("unused or extra grid selected");

   property p_latch;
      !$stable(seg_r) |-> $past(step_en && last_slot);
   endproperty
   a_latch: assert property (p_latch)
      else $error("segments changed outside latch point");

   property p_mode_off;
      !m68 |=> !db_oe_r ##1 !db_oe_r;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("bus driven outside 68-style mode");

   property p_blink;
      blink_cnt_r == BLINK_LAST |=>
         blink_phase_r != $past(blink_phase_r) && blink_cnt_r == 26'h0;
   endproperty
   a_blink: assert property (p_blink)
      else $error("blink phase missed its toggle");

endmodule

// File: inc/vgc_pkg.sv
package vgc_pkg;

   // Clock rate and refresh timing
   localparam int CLK_PERIOD_NS  = 8;
   localparam int STEP_NS        = 1000;
   localparam int STEP_CYC       = STEP_NS / CLK_PERIOD_NS;
   localparam int BLINK_HALF_MS  = 400;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

   // Memory sizes
   localparam int GLYPH_WORDS = 64;
   localparam int GLYPH_AW    = 6;
   localparam int CHAR_WORDS  = 128;
   localparam int CHAR_AW     = 7;

   // Display geometry
   localparam int         GRID_COUNT   = 24;
   localparam int         SEG_COUNT    = 80;
   localparam int         DOTS_PER_ROW = 5;
   localparam int         SLOTS        = 16;
   localparam logic [3:0] SLOT_LAST    = 4'hF;
   localparam logic [4:0] DIGITS_16    = 5'h10;
   localparam logic [4:0] DIGITS_20    = 5'h14;
   localparam logic [4:0] DIGITS_24    = 5'h18;
   localparam logic [2:0] CURSOR_ROW   = 3'h7;
   localparam logic [3:0] USER_HI      = 4'h0;
   localparam logic [4:0] DOTS_ALL     = 5'h1F;
   localparam logic [4:0] DOTS_OFF     = 5'h00;

   // Host port fixed values
   localparam logic       BUSY_VALUE = 1'b0;
   localparam logic [3:0] NIB_IDLE   = 4'h0;

   // Values after reset
   localparam logic       DL_RESET     = 1'b1;
   localparam logic       ID_RESET     = 1'b1;
   localparam logic       DISP_RESET   = 1'b0;
   localparam logic       CURSOR_RESET = 1'b0;
   localparam logic       BLINK_RESET  = 1'b0;
   localparam logic [6:0] AC_RESET     = 7'h00;

endpackage

// File: logic/vgc_glyph_ram.sv
`timescale 1ns/1ps

// User glyph store: one host port, one refresh read port
module vgc_glyph_ram
   import vgc_pkg::*;
#(
   parameter int DEPTH = GLYPH_WORDS,
   parameter int AW    = GLYPH_AW,
   parameter int DW    = 8
)
(
   // Clock
   input  wire logic          clock,
   // Host side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] host_addr,
   input  wire logic [DW-1:0] wr_data,
   output logic      [DW-1:0] host_q,
   // Refresh side
   input  wire logic [AW-1:0] scan_addr,
   output logic      [DW-1:0] scan_q
);

   // Address width must cover the depth exactly
   if (DEPTH != (1 << AW) || DW < DOTS_PER_ROW)
   begin : g_bad_size
      $error("vgc_glyph_ram: unsupported size");
   end

   logic [DW-1:0] mem [DEPTH];

   // Whole array is plain storage; unused slots hold general data
   always_ff @(posedge clock)
   begin
      if (wr_en)
         mem[host_addr] <= wr_data;
   end

   // Separate read ports so refresh never waits on the host
   assign host_q = mem[host_addr];
   assign scan_q = mem[scan_addr];

endmodule

// File: verif/vgc_host_model.sv
`timescale 1ns/1ps

// Host microcontroller on the 68-style parallel bus
module vgc_host_model
   import vgc_pkg::*;
(
   // Clock
   input  wire logic       clock,
   // Bus towards the device
   output logic            host_e,
   output logic            host_rs,
   output logic            host_rw,
   output logic [7:0]      db_in,
   input  wire logic [7:0] db_out
);
   logic four_bit;

   // Idle bus at time zero
   initial
   begin
      four_bit = 1'h0;
      host_e   = 1'h0;
      host_rs  = 1'h0;
      host_rw  = 1'h0;
      db_in    = 8'h00;
   end

   // One strobe: drive after an edge, hold through the capture edge
   task automatic strobe(input logic rs, input logic rw, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clock);
      #1;
      host_rs = rs;
      host_rw = rw;
      db_in   = rw ? ~db_in : d;
      host_e  = 1'h1;
      repeat (2) @(posedge clock);
      #1;
      q      = db_out;
      host_e = 1'h0;
      // Device takes the lines at the edge that first sees E low
      @(posedge clock);
      #1;
      // Released lines never keep the last value; low lines stay at F only in 4-bit mode
      db_in  = four_bit ? {~db_in[7:4], 4'hF} : ~db_in;
   endtask

   // Byte transfer; busy is never checked, two strobes per byte in 4-bit mode
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
      logic [7:0] hi;
      logic [7:0] lo;
      if (four_bit)
      begin
         strobe(rs, rw, {d[7:4], 4'hF}, hi);
         strobe(rs, rw, {d[3:0], 4'hF}, lo);
         q = {hi[7:4], lo[7:4]};
      end
      else
         strobe(rs, rw, d, q);
   endtask
endmodule

// File: verif/vfd_glyph_cursor_and_host_port_bench.sv
`timescale 1ns/1ps

module vfd_glyph_cursor_and_host_port_bench
   import vgc_pkg::*;
;
   typedef struct packed {
      logic       rs;
      logic       rw;
      logic [7:0] d;
      logic [7:0] exp;
   } vgc_row_type;

   logic        clock;
   logic        srst;
   logic        interface_mode_sel;
   logic        bus_style_sel;
   logic        host_e;
   logic        host_rs;
   logic        host_rw;
   logic [7:0]  db_in;
   logic [7:0]  db_out;
   logic        db_oe;
   logic [23:0] grid;
   logic [79:0] seg;
   logic        data_length_bit;
   logic [6:0]  address_pointer;
   logic [79:0] exp_seg;
   logic [7:0]  q;
   logic        saw_oe;
   int          fail_count;
   int          comparisons;
   vgc_row_type rows [13];

   // Short blink period keeps the run brief
   vgc_top #(.BLINK_CYC(64)) DUT
   (
      .clock              (clock),
      .srst               (srst),
      .interface_mode_sel (interface_mode_sel),
      .bus_style_sel      (bus_style_sel),
      .display_size_sel0  (1'h0),
      .display_size_sel1  (1'h0),
      .host_e             (host_e),
      .host_rs            (host_rs),
      .host_rw            (host_rw),
      .db_in              (db_in),
      .db_out             (db_out),
      .db_oe              (db_oe),
      .grid               (grid),
      .seg                (seg),
      .data_length_bit    (data_length_bit),
      .address_pointer    (address_pointer)
   );

   vgc_host_model u_host
   (
      .clock   (clock),
      .host_e  (host_e),
      .host_rs (host_rs),
      .host_rw (host_rw),
      .db_in   (db_in),
      .db_out  (db_out)
   );

   // Clock
   initial
   begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end

   // Any drive of the data bus is remembered
   always @(posedge clock)
      if (db_oe === 1'h1)
         saw_oe = 1'h1;

   task automatic check(input string what, input logic [79:0] exp,
                        input logic [79:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   function automatic logic [4:0] pat(input int r);
      return 5'(r * 3 + 1);
   endfunction

   // Table pass over pointer, storage and status behaviour
   task automatic run_rows;
      for (int i = 0; i < 13; i++)
      begin
         u_host.xfer(rows[i].rs, rows[i].rw, rows[i].d, q);
         if (rows[i].rw)
            check("read", 80'(rows[i].exp), 80'(q));
         else
            check("ptr", 80'(rows[i].exp), 80'(address_pointer));
      end
   endtask

   // Bounded wait for one grid; unused grids must stay off meanwhile
   task automatic wait_grid(input logic [23:0] g);
      int n;
      n = 0;
      while (grid !== g)
      begin
         @(posedge clock);
         #1;
         check("unused grids", 80'h0, 80'(grid[23:16]));
         n++;
         if (n > 40000)
         begin
            fail_count++;
            report_and_stop();
         end
      end
   endtask

   // Main sequence
   initial
   begin
      fail_count = 0;
      comparisons = 0;
      saw_oe = 1'h0;
      srst = 1'h1;
      interface_mode_sel = 1'h1;
      bus_style_sel = 1'h1;
      rows = '{'{1'h0, 1'h0, 8'h85, 8'h05}, '{1'h1, 1'h0, 8'h41, 8'h06},
               '{1'h0, 1'h1, 8'h00, 8'h06}, '{1'h0, 1'h0, 8'h04, 8'h06},
               '{1'h1, 1'h0, 8'h42, 8'h05}, '{1'h0, 1'h0, 8'h06, 8'h05},
               '{1'h1, 1'h1, 8'h00, 8'h41}, '{1'h0, 1'h1, 8'h00, 8'h06},
               '{1'h0, 1'h0, 8'h7F, 8'h3F}, '{1'h1, 1'h0, 8'hA5, 8'h00},
               '{1'h0, 1'h0, 8'h7F, 8'h3F}, '{1'h1, 1'h1, 8'h00, 8'hA5},
               '{1'h0, 1'h0, 8'h02, 8'h00}};
      repeat (4) @(posedge clock);
      #1;
      check("reset out", 80'h0, {db_oe, db_out, grid, seg[46:0]});
      check("reset seg", 80'h0, seg);
      check("reset mode", 80'h1, 80'(data_length_bit));
      check("reset ptr", 80'h0, 80'(address_pointer));
      srst = 1'h0;
      run_rows();
      // Switch to nibble transfers and repeat the table
      u_host.xfer(1'h0, 1'h0, 8'h20, q);
      check("dl 4bit", 80'h0, 80'(data_length_bit));
      u_host.four_bit = 1'h1;
      run_rows();
      u_host.strobe(1'h0, 1'h0, 8'h8F, q);
      check("ptr half", 80'h0, 80'(address_pointer));
      u_host.strobe(1'h0, 1'h0, 8'hAF, q);
      check("ptr full", 80'h0A, 80'(address_pointer));
      u_host.xfer(1'h0, 1'h0, 8'h30, q);
      check("dl 8bit", 80'h1, 80'(data_length_bit));
      u_host.four_bit = 1'h0;
      // Port must ignore strobes unless both selects are high
      for (int k = 1; k < 3; k++)
      begin
         {interface_mode_sel, bus_style_sel} = 2'(k);
         saw_oe = 1'h0;
         u_host.xfer(1'h0, 1'h0, 8'h90, q);
         u_host.xfer(1'h0, 1'h1, 8'h00, q);
         check("ptr off", 80'h0A, 80'(address_pointer));
         check("oe off", 80'h0, 80'(saw_oe));
      end
      {interface_mode_sel, bus_style_sel} = 2'h3;
      // Glyph slot 1; upper data bits must not show, row 7 written as F1H shows as 11H
      u_host.xfer(1'h0, 1'h0, 8'h48, q);
      for (int r = 0; r < 8; r++)
         u_host.xfer(1'h1, 1'h0, (r == 7) ? 8'hF1 : {3'h7, pat(r)}, q);
      u_host.xfer(1'h0, 1'h0, 8'h80, q);
      u_host.xfer(1'h1, 1'h0, 8'h09, q);
      u_host.xfer(1'h0, 1'h0, 8'hC0, q);
      u_host.xfer(1'h1, 1'h0, 8'h01, q);
      u_host.xfer(1'h0, 1'h0, 8'h0E, q);
      u_host.xfer(1'h0, 1'h0, 8'h80, q);
      // Cursor sits on line one of grid 0; line two keeps its stored row
      for (int s = 0; s < 16; s++)
         exp_seg[79 - 5 * s -: 5] = (s % 8 != 7) ? pat(s % 8) :
                                    (s < 8) ? DOTS_ALL : 5'h11;
      wait_grid(24'h2);
      wait_grid(24'h1);
      check("seg", exp_seg, seg);
      report_and_stop();
   end
endmodule
